// [include/option_byte_consts.svh]
// Purpose: Named constants of the option byte decoder
// Assumes: Included by the package, the assertions and the bench
// Notes:   Definitions only
`ifndef OPTION_BYTE_CONSTS_SVH
`define OPTION_BYTE_CONSTS_SVH

`define OPT_ERASED 8'hff
`define OPT0_IRQ_MAP_BIT 1
`define OPT0_PROTECT_BIT 0
`define OPT1_CLK_FILT_BIT 7
`define OPT1_OSC_MSB 6
`define OPT1_OSC_LSB 4
`define OPT1_LVD_MSB 3
`define OPT1_LVD_LSB 2
`define OPT1_WATCHDOG_HALT_RESET_EN_BIT 1
`define OPT1_WATCHDOG_SOFT_ACTIVATION_BIT 0

`define LVD_OFF 2'h3
`define MEM_LAST_ADDR 13'h1fff
`define MEM_ADDR_W 13

`define AXI_ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_WDG_EN_BIT 0
`define STAT_ERASE_BIT 0
`define STAT_LOADED_BIT 1
`define STAT_WDG_ON_BIT 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [include/option_byte_pkg.sv]
// Purpose: Types of the option byte decoder
// Assumes: option_byte_consts.svh holds the numbers
// Notes:   Decoded settings travel as one packed struct
`include "option_byte_consts.svh"
package option_byte_pkg;

  typedef enum logic [2:0] {
    CLK_EXTERNAL,
    CLK_INTERNAL_RC,
    CLK_EXTERNAL_RC,
    CLK_LOW_POWER_RESONATOR,
    CLK_MID_POWER_RESONATOR,
    CLK_MID_SPEED_RESONATOR,
    CLK_FASTEST_RESONATOR
  } clk_src_t;

  typedef struct packed {
    logic irq_port_mapping_sel;
    logic readout_protect;
    logic clock_filter_disable;
    logic [2:0] main_clock_source_sel;
    clk_src_t clk_src;
    logic [1:0] brownout_threshold_sel;
    logic brownout_enable;
    logic watchdog_halt_reset_en;
    logic watchdog_soft_activation;
  } opt_config_t;

endpackage

// [hdl/option_byte_decoder.sv]
// Purpose: Hold two option bytes, decode them into static device settings
// Assumes: Programming pins are asynchronous; halt, watchdog and port irqs are on mclk
// Notes:   Option bytes are not reachable over AXI; only the control register and erase, loaded and watchdog status are
// Contract
// R1 - Option bytes sit outside the memory map; accessed only in programming mode.
// R2 - Unprogrammed option bytes and flash read back as all ones.
// R3 - Programmer writes ones into reserved bits 7:2 of byte 0.
// R4 - Byte 0 bit 1 routes port C irqs to vector b (1) or a (0).
// R5 - Byte 0 bit 0 set blocks external read of program memory.
// R6 - Clearing protection erases all program memory, option bytes excluded.
// R7 - Byte 1 bit 7 zero enables clock filter, one disables it.
// R8 - Byte 1 bits 6:4 select the main clock source.
// R9 - Byte 1 bits 3:2 pick brownout threshold or turn detection off.
// R10 - Byte 1 bit 1 set makes halt with running watchdog cause reset.
// R11 - Byte 1 bit 0 zero keeps watchdog always on; one waits software.
// R12 - Mask ROM parts use fixed option values that cannot be altered.
// R13 - Bytes latch at reset; decoded outputs hold until next reset.
`timescale 1ns/1ps
module option_byte_decoder
  import option_byte_pkg::*;
#(
  parameter bit MASK_ROM = 1'b0,
  parameter logic [7:0] ROM_OPT0 = 8'hff,
  parameter logic [7:0] ROM_OPT1 = 8'hff
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Programming tool pins
  input wire logic prog_mode,
  input wire logic prog_wr,
  input wire logic prog_sel,
  input wire logic [7:0] prog_wdata,
  output logic [7:0] prog_rdata,
  // Events from the core
  input wire logic halt_entry,
  input wire logic watchdog_active,
  input wire logic port_a_irq,
  input wire logic port_b_irq,
  input wire logic port_c_irq,
  // Decoded configuration
  output opt_config_t cfg,
  output logic cfg_loaded,
  output logic watchdog_enable,
  output logic halt_reset_req,
  output logic ext_irq_vector_a,
  output logic ext_irq_vector_b,
  // Program memory erase
  output logic mem_erase_we,
  output logic [`MEM_ADDR_W-1:0] mem_erase_addr,
  output logic erase_busy,
  // AXI4-Lite slave
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic {ST_IDLE, ST_ERASE} erase_state_t;

  logic [1:0] rst_sync;
  logic srst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign srst_n = rst_sync[1];

  // Two-flop synchronisers for the programming pins, third stage for the edge
  localparam int SYNC_W = 11;
  logic [SYNC_W-1:0] pin_meta, pin_sync;
  logic wr_prev;
  logic p_mode, p_wr, p_sel;
  logic [7:0] p_data;

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      wr_prev <= 1'b0;
    end else begin
      pin_meta <= {prog_mode, prog_wr, prog_sel, prog_wdata};
      pin_sync <= pin_meta;
      wr_prev <= p_wr;
    end
  end
  assign {p_mode, p_wr, p_sel, p_data} = pin_sync;

  // Option byte cells, erase engine and latched copy
  logic [7:0] opt_cell [2];
  logic [7:0] next_opt_cell [2];
  logic [7:0] opt0, opt1, next_opt0, next_opt1;
  logic next_cfg_loaded;
  erase_state_t state, next_state;
  logic [`MEM_ADDR_W-1:0] next_mem_erase_addr;
  logic next_mem_erase_we, next_erase_busy;
  logic [7:0] next_prog_rdata;
  logic prog_write;

  assign prog_write = p_wr && !wr_prev && p_mode && !MASK_ROM && state == ST_IDLE; // R1 R12

  always_comb begin
    next_opt_cell = opt_cell;
    next_state = state;
    next_mem_erase_addr = mem_erase_addr;
    next_mem_erase_we = 1'b0;
    next_opt0 = opt0;
    next_opt1 = opt1;
    next_cfg_loaded = 1'b1;
    // Cells only visible to the programming port while in programming mode
    next_prog_rdata = p_mode ? opt_cell[p_sel] : 8'h00; // R1
    if (!cfg_loaded) begin
      next_opt0 = MASK_ROM ? ROM_OPT0 : opt_cell[0]; // R12 R13
      next_opt1 = MASK_ROM ? ROM_OPT1 : opt_cell[1]; // R12 R13
    end
    case (state)
      ST_IDLE: begin
        if (prog_write) begin
          // Reserved bits are stored as written; the tool keeps them at one
          next_opt_cell[p_sel] = p_data; // R3
          if (!p_sel && opt_cell[0][`OPT0_PROTECT_BIT] && !p_data[`OPT0_PROTECT_BIT]) begin
            next_state = ST_ERASE; // R6
            next_mem_erase_addr = '0;
            next_mem_erase_we = 1'b1;
          end
        end
      end
      ST_ERASE: begin
        // Memory rewrites each word from its own latches; option cells untouched
        if (mem_erase_addr == `MEM_LAST_ADDR) begin
          next_state = ST_IDLE; // R6
        end else begin
          next_mem_erase_addr = mem_erase_addr + `MEM_ADDR_W'(1);
          next_mem_erase_we = 1'b1; // R6
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_erase_busy = next_state == ST_ERASE;
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      opt_cell[0] <= `OPT_ERASED; // R2
      opt_cell[1] <= `OPT_ERASED; // R2
      state <= ST_IDLE;
      mem_erase_addr <= '0;
      mem_erase_we <= 1'b0;
      erase_busy <= 1'b0;
      opt0 <= `OPT_ERASED;
      opt1 <= `OPT_ERASED;
      cfg_loaded <= 1'b0;
      prog_rdata <= 8'h00;
    end else begin
      opt_cell <= next_opt_cell;
      state <= next_state;
      mem_erase_addr <= next_mem_erase_addr;
      mem_erase_we <= next_mem_erase_we;
      erase_busy <= next_erase_busy;
      opt0 <= next_opt0;
      opt1 <= next_opt1;
      cfg_loaded <= next_cfg_loaded;
      prog_rdata <= next_prog_rdata;
    end
  end

  // Decode of the latched copy; it only changes in the first cycle after reset
  opt_config_t next_cfg;
  logic [2:0] osc;

  always_comb begin
    osc = opt1[`OPT1_OSC_MSB:`OPT1_OSC_LSB];
    next_cfg.irq_port_mapping_sel = opt0[`OPT0_IRQ_MAP_BIT]; // R4
    next_cfg.readout_protect = opt0[`OPT0_PROTECT_BIT]; // R5
    next_cfg.clock_filter_disable = opt1[`OPT1_CLK_FILT_BIT]; // R7
    next_cfg.main_clock_source_sel = osc; // R8
    case (osc)
      3'h7: next_cfg.clk_src = CLK_EXTERNAL; // R8
      3'h6: next_cfg.clk_src = CLK_INTERNAL_RC;
      3'h5, 3'h4: next_cfg.clk_src = CLK_EXTERNAL_RC;
      3'h3: next_cfg.clk_src = CLK_LOW_POWER_RESONATOR;
      3'h2: next_cfg.clk_src = CLK_MID_POWER_RESONATOR;
      3'h1: next_cfg.clk_src = CLK_MID_SPEED_RESONATOR;
      default: next_cfg.clk_src = CLK_FASTEST_RESONATOR;
    endcase
    next_cfg.brownout_threshold_sel = opt1[`OPT1_LVD_MSB:`OPT1_LVD_LSB]; // R9
    next_cfg.brownout_enable = opt1[`OPT1_LVD_MSB:`OPT1_LVD_LSB] != `LVD_OFF; // R9
    next_cfg.watchdog_halt_reset_en = opt1[`OPT1_WATCHDOG_HALT_RESET_EN_BIT]; // R10
    next_cfg.watchdog_soft_activation = opt1[`OPT1_WATCHDOG_SOFT_ACTIVATION_BIT]; // R11
  end

  // Run-time effects of the settings
  logic sw_wdg_en, next_sw_wdg_en;
  logic next_watchdog_enable, next_halt_reset_req;
  logic next_vec_a, next_vec_b;

  always_comb begin
    next_watchdog_enable = cfg_loaded && (!cfg.watchdog_soft_activation || sw_wdg_en); // R11
    next_halt_reset_req = cfg_loaded && halt_entry && watchdog_active
                          && cfg.watchdog_halt_reset_en; // R10
    next_vec_a = port_a_irq || (!cfg.irq_port_mapping_sel && port_c_irq); // R4
    next_vec_b = port_b_irq || (cfg.irq_port_mapping_sel && port_c_irq); // R4
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      cfg <= '0;
      watchdog_enable <= 1'b0;
      halt_reset_req <= 1'b0;
      ext_irq_vector_a <= 1'b0;
      ext_irq_vector_b <= 1'b0;
    end else begin
      cfg <= next_cfg; // R13
      watchdog_enable <= next_watchdog_enable;
      halt_reset_req <= next_halt_reset_req;
      ext_irq_vector_a <= next_vec_a;
      ext_irq_vector_b <= next_vec_b;
    end
  end

  // AXI4-Lite slave: control and status only
  logic aw_have, w_have, next_aw_have, next_w_have;
  logic [`AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, status;

  always_comb begin
    status = 32'h0;
    status[`STAT_ERASE_BIT] = erase_busy;
    status[`STAT_LOADED_BIT] = cfg_loaded;
    status[`STAT_WDG_ON_BIT] = watchdog_enable;
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_sw_wdg_en = sw_wdg_en;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_have && w_have && !s_axi_bvalid) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      if (aw_addr == `REG_CTRL) begin
        if (w_strb[0]) begin
          next_sw_wdg_en = w_data[`CTRL_WDG_EN_BIT]; // R11
        end
      end else if (aw_addr != `REG_STATUS) begin
        next_bresp = `RESP_SLVERR;
      end
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL: next_rdata = {31'h0, sw_wdg_en};
        `REG_STATUS: next_rdata = status;
        default: begin
          next_rdata = 32'h0;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      sw_wdg_en <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      sw_wdg_en <= next_sw_wdg_en;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

// [bench/option_byte_decoder_props.sv]
// Purpose: Assertions on the option byte decoder ports
// Assumes: One clock domain, arst_n low clears everything
// Notes: Bound into every decoder instance
`timescale 1ns/1ps
`include "option_byte_consts.svh"
module option_byte_decoder_props
  import option_byte_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Inputs watched
  input wire logic prog_mode,
  input wire logic halt_entry,
  input wire logic watchdog_active,
  input wire logic port_a_irq,
  input wire logic port_c_irq,
  // Outputs watched
  input wire logic [7:0] prog_rdata,
  input wire opt_config_t cfg,
  input wire logic cfg_loaded,
  input wire logic halt_reset_req,
  input wire logic ext_irq_vector_a,
  input wire logic ext_irq_vector_b,
  input wire logic mem_erase_we,
  input wire logic [`MEM_ADDR_W-1:0] mem_erase_addr,
  input wire logic erase_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence sweep_start;
    $rose(erase_busy);
  endsequence
  sequence sweep_last;
    mem_erase_we && mem_erase_addr == `MEM_LAST_ADDR;
  endsequence
  chk_halt_reset_req: assert property (
    cfg.watchdog_halt_reset_en && halt_entry && watchdog_active |=> halt_reset_req)
    else $error("halt with watchdog gave no reset");
  chk_halt_quiet: assert property (
    cfg_loaded && !(halt_entry && watchdog_active) |=> !halt_reset_req)
    else $error("reset request without cause");
  chk_route_c_b: assert property (
    cfg_loaded && cfg.irq_port_mapping_sel && port_c_irq |=> ext_irq_vector_b)
    else $error("port c not on vector b");
  chk_route_c_a: assert property (
    cfg_loaded && cfg.irq_port_mapping_sel && port_c_irq && !port_a_irq |=> !ext_irq_vector_a)
    else $error("port c leaked to vector a");
  chk_cfg_frozen: assert property ($past(cfg_loaded, 2) |-> $stable(cfg))
    else $error("settings changed without reset");
  chk_lvd_off: assert property (
    cfg.brownout_threshold_sel == `LVD_OFF |-> !cfg.brownout_enable)
    else $error("brownout on in off code");
  chk_osc_external: assert property (
    cfg.main_clock_source_sel == 3'h7 |-> cfg.clk_src == CLK_EXTERNAL)
    else $error("clock source decode wrong");
  chk_sweep_start: assert property (
    sweep_start |-> mem_erase_we && mem_erase_addr == '0)
    else $error("erase did not start at zero");
  chk_sweep_step: assert property (
    mem_erase_we && mem_erase_addr != `MEM_LAST_ADDR
    |=> mem_erase_we && mem_erase_addr == $past(mem_erase_addr) + 1'b1)
    else $error("erase address skipped");
  chk_sweep_end: assert property (sweep_last |=> !erase_busy && !mem_erase_we)
    else $error("erase ran past last word");
  chk_rdata_closed: assert property (!prog_mode [*4] |-> prog_rdata == 8'h00)
    else $error("option byte visible outside programming");
endmodule
bind option_byte_decoder option_byte_decoder_props props (.mclk, .arst_n, .prog_mode,
  .halt_entry, .watchdog_active, .port_a_irq, .port_c_irq, .prog_rdata, .cfg, .cfg_loaded,
  .halt_reset_req, .ext_irq_vector_a, .ext_irq_vector_b, .mem_erase_we, .mem_erase_addr,
  .erase_busy);

// [bench/prog_tool_model.sv]
// Purpose: Programming tool model driving the option byte pins
// Assumes: Pins pass synchronisers, so every step is spaced in mclk cycles
// Notes: Data lines show the inverse of the last byte once hold time is over
`timescale 1ns/1ps
module prog_tool_model (
  // Clock
  input wire logic mclk,
  // Programming pins
  output logic prog_mode,
  output logic prog_wr,
  output logic prog_sel,
  output logic [7:0] prog_wdata
);
  initial begin
    prog_mode = 1'b0;
    prog_wr = 1'b0;
    prog_sel = 1'b0;
    prog_wdata = 8'h00;
  end
  task automatic enter(input logic on);
    @(posedge mclk);
    prog_mode <= on;
    repeat (5) @(posedge mclk);
  endtask
  task automatic pick(input logic s);
    @(posedge mclk);
    prog_sel <= s;
    repeat (5) @(posedge mclk);
  endtask
  task automatic write_byte(input logic s, input logic [7:0] d);
    @(posedge mclk);
    prog_sel <= s;
    prog_wdata <= s ? d : {6'h3f, d[1:0]};
    repeat (3) @(posedge mclk);
    prog_wr <= 1'b1;
    repeat (3) @(posedge mclk);
    prog_wr <= 1'b0;
    repeat (2) @(posedge mclk);
    prog_wdata <= ~prog_wdata;
    repeat (3) @(posedge mclk);
  endtask
endmodule

// [bench/option_byte_decoder_tb.sv]
// Purpose: Self-checking bench of the option byte decoder
// Assumes: Flash part, cells come up erased after every reset
// Notes: Erase sweep runs its full length of 8192 words, so the run is a little over 8192 cycles
`timescale 1ns/1ps
`include "option_byte_consts.svh"
module option_byte_decoder_tb
  import option_byte_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic halt_entry = 0, watchdog_active = 0, port_a_irq = 0, port_b_irq = 0, port_c_irq = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic prog_mode, prog_wr, prog_sel, cfg_loaded, watchdog_enable, halt_reset_req;
  logic ext_irq_vector_a, ext_irq_vector_b, mem_erase_we, erase_busy, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] prog_wdata, prog_rdata;
  logic [`MEM_ADDR_W-1:0] mem_erase_addr;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  opt_config_t cfg;
  // Second instance is a mask part, so hard-wired values and byte 0 bit 1 low get exercised
  opt_config_t cfg_rom;
  logic rom_vec_a, rom_vec_b;
  logic [7:0] rom_rdata;
  int bad_count = 0, checks = 0, cyc = 0, erase_count = 0;
  always #5 mclk = ~mclk;
  prog_tool_model tool (.mclk, .prog_mode, .prog_wr, .prog_sel, .prog_wdata);
  option_byte_decoder dut (.mclk, .arst_n, .prog_mode, .prog_wr, .prog_sel, .prog_wdata,
    .prog_rdata, .halt_entry, .watchdog_active, .port_a_irq, .port_b_irq, .port_c_irq, .cfg,
    .cfg_loaded, .watchdog_enable, .halt_reset_req, .ext_irq_vector_a, .ext_irq_vector_b,
    .mem_erase_we, .mem_erase_addr, .erase_busy, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  option_byte_decoder #(.MASK_ROM(1'b1), .ROM_OPT0(8'hfc), .ROM_OPT1(8'h04)) dut_rom (
    .mclk, .arst_n, .prog_mode, .prog_wr, .prog_sel, .prog_wdata, .prog_rdata(rom_rdata),
    .halt_entry, .watchdog_active, .port_a_irq, .port_b_irq, .port_c_irq, .cfg(cfg_rom),
    .cfg_loaded(), .watchdog_enable(), .halt_reset_req(), .ext_irq_vector_a(rom_vec_a),
    .ext_irq_vector_b(rom_vec_b), .mem_erase_we(), .mem_erase_addr(), .erase_busy(),
    .s_axi_awaddr(8'h00), .s_axi_awvalid(1'b0), .s_axi_awready(), .s_axi_wdata(32'h0),
    .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(1'b0), .s_axi_araddr(8'h00), .s_axi_arvalid(1'b0), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0));
  task automatic end_sim();
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic opt_config_t decode(input logic [7:0] b0, input logic [7:0] b1);
    opt_config_t c;
    c.irq_port_mapping_sel = b0[1];
    c.readout_protect = b0[0];
    c.clock_filter_disable = b1[7];
    c.main_clock_source_sel = b1[6:4];
    case (b1[6:4])
      3'h7: c.clk_src = CLK_EXTERNAL;
      3'h6: c.clk_src = CLK_INTERNAL_RC;
      3'h5, 3'h4: c.clk_src = CLK_EXTERNAL_RC;
      3'h3: c.clk_src = CLK_LOW_POWER_RESONATOR;
      3'h2: c.clk_src = CLK_MID_POWER_RESONATOR;
      3'h1: c.clk_src = CLK_MID_SPEED_RESONATOR;
      default: c.clk_src = CLK_FASTEST_RESONATOR;
    endcase
    c.brownout_threshold_sel = b1[3:2];
    c.brownout_enable = (b1[3:2] != `LVD_OFF);
    c.watchdog_halt_reset_en = b1[1];
    c.watchdog_soft_activation = b1[0];
    return c;
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("CHECK FAILED at %0t: write response timed out", $time);
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("CHECK FAILED at %0t: read data timed out", $time);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset();
    int n = 0;
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    while (cfg_loaded !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_decode();
    cmp(32'(cfg), 32'(decode(8'hff, 8'hff)), "settings");
    cmp(32'(watchdog_enable), 32'h0, "watchdog waits");
    cmp(32'(prog_rdata), 32'h0, "bytes hidden");
    cmp(32'(cfg_rom), 32'(decode(8'hfc, 8'h04)), "rom settings");
  endtask
  task automatic t_events();
    logic [4:0] v;
    for (int i = 0; i < 32; i++) begin
      v = i[4:0];
      {halt_entry, watchdog_active, port_a_irq, port_b_irq, port_c_irq} <= v;
      repeat (2) @(posedge mclk);
      cmp(32'(ext_irq_vector_a), 32'(v[2]), "vector a");
      cmp(32'(ext_irq_vector_b), 32'(v[1] | v[0]), "vector b");
      cmp(32'(halt_reset_req), 32'(v[4] & v[3]), "halt reset");
      cmp(32'(rom_vec_a), 32'(v[2] | v[0]), "rom vector a");
      cmp(32'(rom_vec_b), 32'(v[1]), "rom vector b");
    end
    {halt_entry, watchdog_active, port_a_irq, port_b_irq, port_c_irq} <= 5'h00;
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`REG_STATUS, d, r);
    cmp(d, 32'h2, "status loaded");
    axi_wr(`REG_CTRL, 32'h1, r);
    cmp(32'(r), 32'(`RESP_OKAY), "ctrl write resp");
    axi_rd(`REG_STATUS, d, r);
    cmp(d, 32'h6, "status watchdog");
    cmp(32'(watchdog_enable), 32'h1, "software enable");
    axi_rd(8'h08, d, r);
    cmp({d[29:0], r}, {30'h0, `RESP_SLVERR}, "unmapped read");
    axi_wr(`REG_CTRL, 32'h0, r);
    // The enable output is registered one edge after the register itself
    @(posedge mclk);
    cmp(32'(watchdog_enable), 32'h0, "software disable");
  endtask
  always @(posedge mclk) begin
    if (mem_erase_we === 1'b1) erase_count <= erase_count + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic t_prog();
    int n = 0;
    tool.enter(1'b1);
    tool.pick(1'b1);
    cmp(32'(prog_rdata), 32'(`OPT_ERASED), "byte 1 erased");
    tool.write_byte(1'b1, 8'h00);
    cmp(32'(prog_rdata), 32'h0, "byte 1 written");
    cmp(32'(rom_rdata), 32'hff, "rom cell locked");
    tool.write_byte(1'b0, 8'h00);
    while (erase_busy !== 1'b0 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    cmp(erase_count, 32'd8192, "erase words");
    tool.pick(1'b0);
    cmp(32'(prog_rdata), 32'hfc, "byte 0 readback");
    cmp(32'(cfg), 32'(decode(8'hff, 8'hff)), "settings held");
    tool.enter(1'b0);
    cmp(32'(prog_rdata), 32'h0, "port closed");
  endtask
  initial begin
    do_reset();
    t_decode();
    t_events();
    t_regs();
    t_prog();
    do_reset();
    t_decode();
    end_sim();
  end
endmodule
